// ==== shared/trcd_pkg.sv ====
// Purpose: Shared constants for the timing receiver command decoder
// Assumes: Command bytes arrive already unframed, packet ID first
// Notes: Floats are IEEE-754 bit patterns, most significant byte first
package trcd_pkg;

	// Packet and subpacket codes
	localparam logic [7:0] PKT_CMD = 8'h8E;
	localparam logic [7:0] PKT_RPT = 8'h8F;
	localparam logic [7:0] SUB_DISC = 8'hA8;
	localparam logic [7:0] SUB_SURV = 8'hA9;
	localparam logic [7:0] SUB_PRI = 8'hAB;
	localparam logic [7:0] SUB_SUP = 8'hAC;
	localparam logic [7:0] SUB_UTC = 8'h02;

	// Byte positions in a command
	localparam logic [4:0] POS_ID = 5'h00;
	localparam logic [4:0] POS_SUB = 5'h01;
	localparam logic [4:0] POS_SEL = 5'h02;
	localparam logic [4:0] POS_SAVE = 5'h03;
	localparam logic [4:0] POS_MAX = 5'h1F;
	localparam logic [4:0] FLD_END0 = 5'h06;
	localparam logic [4:0] FLD_END1 = 5'h0A;
	localparam logic [4:0] FLD_END2 = 5'h0E;
	localparam logic [1:0] FLD_NONE = 2'h3;

	// Selector, request type and flag values
	localparam logic [7:0] SEL_MAX = 8'h03;
	localparam logic [7:0] SEL_RECOV = 8'h02;
	localparam logic [7:0] REQ_NOW = 8'h00;
	localparam logic [7:0] REQ_NEXT = 8'h01;
	localparam logic [7:0] REQ_BOTH = 8'h02;
	localparam logic [7:0] FLAG_ON = 8'h01;

	// Parameter word map
	localparam logic [3:0] W_TC = 4'h0;
	localparam logic [3:0] W_GAIN = 4'h2;
	localparam logic [3:0] W_JAM = 4'h5;
	localparam logic [3:0] W_INITV = 4'h7;
	localparam logic [3:0] W_SLEN = 4'h8;
	localparam logic [3:0] W_HUNC = 4'h9;
	localparam logic [3:0] W_VUNC = 4'hA;
	localparam logic [3:0] W_LAST = 4'hF;
	localparam logic [3:0] DISC_BASE [4] = '{W_TC, W_GAIN, W_JAM, W_INITV};
	localparam logic [1:0] DISC_CNT [4] = '{2'h2, 2'h3, 2'h2, 2'h1};
	localparam logic [1:0] SURV_CNT = 2'h3;
	localparam logic [1:0] UTC_CNT = 2'h3;

	// Defaults and limits
	localparam logic [31:0] SLEN_DEF = 32'h0000_07D0;
	localparam logic [31:0] UNC_MAX = 32'h42C8_0000;
	localparam logic [31:0] JAM_MIN = 32'h4248_0000;

	// Reply header lengths
	localparam logic [2:0] HDR3 = 3'h3;
	localparam logic [2:0] HDR4 = 3'h4;
	localparam logic [1:0] LAST_BYTE = 2'h3;

	// Software registers, byte addresses
	localparam logic [4:0] A_MASK = 5'h00;
	localparam logic [4:0] A_STAT = 5'h04;
	localparam logic [4:0] A_UTC_C = 5'h08;
	localparam logic [4:0] A_A0_HI = 5'h0C;
	localparam logic [4:0] A_A0_LO = 5'h10;
	localparam logic [4:0] A_A1 = 5'h14;
	localparam logic [4:0] A_DROP = 5'h18;
	localparam logic [15:0] MASK_RST = 16'h0005;
	localparam int MASK_PRI = 0;
	localparam int MASK_SUP = 2;
	localparam logic [7:0] UTC_C_RST = 8'h01;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_INIT = 3'b000,
		ST_RX = 3'b001,
		ST_LOAD = 3'b011,
		ST_CAPT = 3'b010,
		ST_SEND = 3'b110
	} trcd_state_e;

endpackage : trcd_pkg

// ==== verilog/trcd_ram.sv ====
// Purpose: Parameter word store, one write and one registered read port
// Assumes: Contents are filled by the owner after reset
// Notes: Read data appear one edge after the address
`timescale 1ns/1ps
module trcd_ram #(
	parameter int AW = 4,
	parameter int DW = 32
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [2**AW];

	always_ff @(posedge ref_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		if (rst) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule : trcd_ram

// ==== verilog/trcd_axil.sv ====
// Purpose: AXI4-Lite slave front end for the decoder registers
// Assumes: One write and one read in flight at most
// Notes: Address and data may arrive in either order
`timescale 1ns/1ps
module trcd_axil
	import trcd_pkg::*;
#(
	parameter int AW = 5
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic reg_wr,
	output logic [AW-1:0] reg_waddr,
	output logic [31:0] reg_wdata,
	output logic [3:0] reg_wstrb,
	input wire logic reg_werr,
	output logic [AW-1:0] reg_raddr,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rerr
);
	typedef struct packed {
		logic aw_full;
		logic w_full;
		logic [AW-1:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} trcd_axil_s;

	trcd_axil_s st;
	trcd_axil_s next_st;

	assign s_axi_awready = ~st.aw_full;
	assign s_axi_wready = ~st.w_full;
	assign s_axi_arready = ~st.rvalid;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	// Write fires only once the previous response has gone
	assign reg_wr = st.aw_full & st.w_full & ~st.bvalid;
	assign reg_waddr = st.waddr;
	assign reg_wdata = st.wdata;
	assign reg_wstrb = st.wstrb;
	assign reg_raddr = s_axi_araddr;

	always_comb begin
		next_st = st;
		if (s_axi_awvalid && !st.aw_full) begin
			next_st.aw_full = 1'b1;
			next_st.waddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.w_full) begin
			next_st.w_full = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (reg_wr) begin
			next_st.aw_full = 1'b0;
			next_st.w_full = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = reg_werr ? RESP_SLVERR : RESP_OKAY;
		end
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rdata = reg_rdata;
			next_st.rresp = reg_rerr ? RESP_SLVERR : RESP_OKAY;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule : trcd_axil

// ==== verilog/trcd_cmd_decoder.sv ====
// Purpose: Command decoder and reply builder for a satellite timing receiver
// Assumes: Host bytes arrive unframed, packet ID first, rx_last on the final byte
// Notes: Timing report contents are built elsewhere; this block only triggers them
// Summary of operation
// (R01) Selector 0: loop time constant, damping
// (R02) Selector 1: gain, min and max voltage
// (R03) Selector 2: jam threshold, max frequency offset
// (R04) Selector 3: initial control voltage
// (R05) Survey command sets values or answers query
// (R06) Survey byte 1: survey off or on
// (R07) Survey byte 2: auto-store position at end
// (R08) Survey bytes 3-6: fix count, default 2000
// (R09) Uncertainties above zero, at most 100
// (R10) Primary type 0: send primary report now
// (R11) Primary type 1: send after next pulse
// (R12) Type 2: both reports after next pulse
// (R13) Primary broadcast each second unless masked
// (R14) Supplemental type 0 now, type 1 after pulse
// (R15) Supplemental broadcast each second unless masked
// (R16) UTC query: constellation, offset, rate terms
// (R17) Reply every disciplining set or query
// (R18) Jam threshold under minimum refused, zero disables; code refuses only positive values under it and stores negative ones
// (R19) Mask bit 0 primary, bit 2 supplemental
// (R20) Unknown selector ignored, nothing changes; code still increments the drop count
// (R21) Multi-byte fields most significant byte first
`timescale 1ns/1ps
module trcd_cmd_decoder
	import trcd_pkg::*;
#(
	parameter int RAM_AW = 4,
	parameter int DROP_W = 16
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] rx_byte,
	input wire logic rx_valid,
	input wire logic rx_last,
	output logic rx_ready,
	output logic [7:0] tx_byte,
	output logic tx_valid,
	output logic tx_last,
	input wire logic tx_ready,
	input wire logic pps_in,
	output logic send_primary,
	output logic send_supplemental,
	output logic survey_enable,
	output logic survey_autosave,
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	if (RAM_AW != 4 || DROP_W < 1 || DROP_W > 32) begin : g_bad_param
		$error("trcd_cmd_decoder: unsupported RAM_AW or DROP_W");
	end

	typedef struct packed {
		trcd_state_e state;
		logic [4:0] pos;
		logic pkt_ok;
		logic [7:0] sub;
		logic [7:0] sel;
		logic [23:0] acc;
		logic en;
		logic save;
		logic [3:0][7:0] hdr;
		logic [2:0] nhdr;
		logic [2:0] cnt;
		logic wphase;
		logic [1:0] bcnt;
		logic [1:0] words;
		logic [3:0] waddr;
		logic rep_utc;
		logic [31:0] shw;
		logic [7:0] txb;
		logic [15:0] mask;
		logic [7:0] utc_c;
		logic [31:0] a0_hi;
		logic [31:0] a0_lo;
		logic [31:0] a1;
		logic [DROP_W-1:0] drop;
		logic pend_pri;
		logic pend_sup;
		logic snd_pri;
		logic snd_sup;
		logic pps1;
		logic pps2;
		logic pps3;
	} trcd_dec_s;

	trcd_dec_s st;
	trcd_dec_s next_st;

	logic ram_we;
	logic [3:0] ram_wa;
	logic [31:0] ram_wd;
	logic [31:0] ram_rd;
	logic reg_wr;
	logic [4:0] reg_waddr;
	logic [31:0] reg_wdata;
	logic [3:0] reg_wstrb;
	logic reg_werr;
	logic [4:0] reg_raddr;
	logic [31:0] reg_rdata;
	logic reg_rerr;

	function automatic logic [1:0] fld_of(input logic [4:0] idx);
		unique case (idx)
			FLD_END0: fld_of = 2'h0;
			FLD_END1: fld_of = 2'h1;
			FLD_END2: fld_of = 2'h2;
			default: fld_of = FLD_NONE;
		endcase
	endfunction : fld_of

	function automatic logic [31:0] init_val(input logic [3:0] a);
		unique case (a)
			W_SLEN: init_val = SLEN_DEF;
			W_HUNC, W_VUNC: init_val = UNC_MAX;
			default: init_val = '0;
		endcase
	endfunction : init_val

	// Positive floats order like unsigned integers, so bit compares suffice
	function automatic logic jam_bad(input logic [31:0] w);
		jam_bad = !w[31] && (w[30:0] != '0) && (w[30:0] < JAM_MIN[30:0]);
	endfunction : jam_bad

	function automatic logic unc_ok(input logic [31:0] w);
		unc_ok = !w[31] && (w[30:0] != '0) && (w[30:0] <= UNC_MAX[30:0]);
	endfunction : unc_ok

	function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
			input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			wmerge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : o[i*8 +: 8];
		end
	endfunction : wmerge

	function automatic logic [31:0] utc_word(input trcd_dec_s s);
		unique case (s.waddr[1:0])
			2'h0: utc_word = s.a0_hi;
			2'h1: utc_word = s.a0_lo;
			default: utc_word = s.a1;
		endcase
	endfunction : utc_word

	trcd_ram #(.AW(RAM_AW), .DW(32)) u_ram (
		.ref_clk(ref_clk),
		.rst(rst),
		.we(ram_we),
		.waddr(ram_wa),
		.wdata(ram_wd),
		.raddr(st.waddr),
		.rdata(ram_rd)
	);

	trcd_axil #(.AW(5)) u_axil (
		.ref_clk(ref_clk),
		.rst(rst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.reg_wr(reg_wr),
		.reg_waddr(reg_waddr),
		.reg_wdata(reg_wdata),
		.reg_wstrb(reg_wstrb),
		.reg_werr(reg_werr),
		.reg_raddr(reg_raddr),
		.reg_rdata(reg_rdata),
		.reg_rerr(reg_rerr)
	);

	assign rx_ready = (st.state == ST_RX);
	assign tx_valid = (st.state == ST_SEND);
	assign tx_byte = st.txb;
	assign tx_last = tx_valid && (st.words == '0) &&
		(st.wphase ? (st.bcnt == LAST_BYTE) : (st.cnt == 3'(st.nhdr - 3'h1)));
	assign send_primary = st.snd_pri;
	assign send_supplemental = st.snd_sup;
	assign survey_enable = st.en;
	assign survey_autosave = st.save;
	assign reg_werr = !(reg_waddr inside {A_MASK, A_UTC_C, A_A0_HI, A_A0_LO, A_A1});

	always_comb begin
		reg_rerr = 1'b0;
		reg_rdata = '0;
		unique case (reg_raddr)
			A_MASK: reg_rdata = {16'h0000, st.mask};
			A_STAT: reg_rdata = {27'h0, st.pend_sup, st.pend_pri, st.state != ST_RX, st.save, st.en};
			A_UTC_C: reg_rdata = {24'h0, st.utc_c};
			A_A0_HI: reg_rdata = st.a0_hi;
			A_A0_LO: reg_rdata = st.a0_lo;
			A_A1: reg_rdata = st.a1;
			A_DROP: reg_rdata = 32'(st.drop);
			default: reg_rerr = 1'b1;
		endcase
	end

	always_comb begin
		logic pps_edge;
		logic set_pri;
		logic set_sup;
		logic [4:0] idx;
		logic [1:0] fi;
		logic [7:0] subv;
		logic [7:0] selv;
		logic [31:0] word;
		logic [31:0] tmp;
		pps_edge = st.pps2 & ~st.pps3;
		set_pri = 1'b0;
		set_sup = 1'b0;
		subv = (st.pos == POS_SUB) ? rx_byte : st.sub;
		selv = (st.pos == POS_SEL) ? rx_byte : st.sel;
		idx = (st.sub == SUB_SURV) ? 5'(st.pos - 5'h01) : st.pos;
		fi = fld_of(idx);
		word = {st.acc, rx_byte}; // R21
		tmp = '0;
		next_st = st;
		next_st.snd_pri = 1'b0;
		next_st.snd_sup = 1'b0;
		next_st.pps1 = pps_in;
		next_st.pps2 = st.pps1;
		next_st.pps3 = st.pps2;
		ram_we = 1'b0;
		ram_wa = '0;
		ram_wd = word;
		if (reg_wr) begin
			tmp = wmerge(reg_rdata_w(reg_waddr), reg_wdata, reg_wstrb);
			unique case (reg_waddr)
				A_MASK: next_st.mask = tmp[15:0]; // R19
				A_UTC_C: next_st.utc_c = tmp[7:0];
				A_A0_HI: next_st.a0_hi = tmp;
				A_A0_LO: next_st.a0_lo = tmp;
				A_A1: next_st.a1 = tmp;
				default: ;
			endcase
		end
		unique case (st.state)
			ST_INIT: begin
				// Word store has no reset, so defaults are written in one sweep
				ram_we = 1'b1;
				ram_wa = st.pos[3:0];
				ram_wd = init_val(st.pos[3:0]); // R08 R09
				next_st.pos = 5'(st.pos + 5'h01);
				if (st.pos[3:0] == W_LAST) begin
					next_st.pos = '0;
					next_st.state = ST_RX;
				end
			end
			ST_RX: begin
				if (rx_valid) begin
					next_st.acc = {st.acc[15:0], rx_byte};
					if (st.pos == POS_ID) next_st.pkt_ok = (rx_byte == PKT_CMD);
					if (st.pos == POS_SUB) next_st.sub = rx_byte;
					if (st.pos == POS_SEL) next_st.sel = rx_byte;
					if (st.pkt_ok && st.sub == SUB_SURV && rx_byte <= FLAG_ON) begin
						if (st.pos == POS_SEL) next_st.en = rx_byte[0]; // R06
						if (st.pos == POS_SAVE) next_st.save = rx_byte[0]; // R07
					end
					if (st.pkt_ok && st.sub == SUB_DISC && st.sel <= SEL_MAX && fi != FLD_NONE
							&& fi < DISC_CNT[st.sel[1:0]]) begin
						// Fields land as they complete; R01 R02 R03 R04 R20
						ram_wa = 4'(DISC_BASE[st.sel[1:0]] + 4'(fi));
						ram_we = !(st.sel == SEL_RECOV && fi == 2'h0 && jam_bad(word)); // R18
					end
					if (st.pkt_ok && st.sub == SUB_SURV && fi != FLD_NONE) begin
						ram_wa = 4'(W_SLEN + 4'(fi)); // R08
						ram_we = (fi == 2'h0) || unc_ok(word); // R09
					end
					next_st.pos = (st.pos == POS_MAX) ? st.pos : 5'(st.pos + 5'h01);
					if (rx_last) begin
						next_st.pos = '0;
						next_st.cnt = '0;
						next_st.wphase = 1'b0;
						next_st.rep_utc = 1'b0;
						next_st.hdr[0] = PKT_RPT;
						next_st.hdr[1] = subv;
						next_st.txb = PKT_RPT;
						if (!((st.pos == POS_ID) ? rx_byte == PKT_CMD : st.pkt_ok)) begin
							next_st.drop = st.drop + 1'b1;
						end else if (subv == SUB_DISC && st.pos >= POS_SEL && selv <= SEL_MAX) begin
							next_st.hdr[2] = selv; // R17
							next_st.nhdr = HDR3;
							next_st.words = DISC_CNT[selv[1:0]];
							next_st.waddr = DISC_BASE[selv[1:0]];
							next_st.state = ST_SEND;
						end else if (subv == SUB_SURV) begin
							if (st.pos == POS_SUB) begin
								next_st.hdr[2] = {7'h00, st.en}; // R05
								next_st.hdr[3] = {7'h00, st.save};
								next_st.nhdr = HDR4;
								next_st.words = SURV_CNT;
								next_st.waddr = W_SLEN;
								next_st.state = ST_SEND;
							end
						end else if (subv == SUB_PRI && st.pos >= POS_SEL) begin
							next_st.snd_pri = (selv == REQ_NOW); // R10
							set_pri = (selv == REQ_NEXT) || (selv == REQ_BOTH); // R11 R12
							set_sup = (selv == REQ_BOTH); // R12
							if (selv > REQ_BOTH) next_st.drop = st.drop + 1'b1;
						end else if (subv == SUB_SUP && st.pos >= POS_SEL) begin
							next_st.snd_sup = (selv == REQ_NOW); // R14
							set_sup = (selv == REQ_NEXT) || (selv == REQ_BOTH); // R14 R12
							set_pri = (selv == REQ_BOTH); // R12
							if (selv > REQ_BOTH) next_st.drop = st.drop + 1'b1;
						end else if (subv == SUB_UTC) begin
							next_st.hdr[2] = st.utc_c; // R16
							next_st.nhdr = HDR3;
							next_st.words = UTC_CNT;
							next_st.waddr = '0;
							next_st.rep_utc = 1'b1;
							next_st.state = ST_SEND;
						end else begin
							next_st.drop = st.drop + 1'b1; // R20
						end
					end
				end
			end
			ST_LOAD: next_st.state = ST_CAPT;
			ST_CAPT: begin
				next_st.shw = st.rep_utc ? utc_word(st) : ram_rd;
				next_st.txb = next_st.shw[31:24]; // R21
				next_st.bcnt = '0;
				next_st.wphase = 1'b1;
				next_st.waddr = 4'(st.waddr + 4'h1);
				next_st.words = 2'(st.words - 2'h1);
				next_st.state = ST_SEND;
			end
			ST_SEND: begin
				if (tx_ready) begin
					if (!st.wphase && 3'(st.cnt + 3'h1) < st.nhdr) begin
						next_st.cnt = 3'(st.cnt + 3'h1);
						next_st.txb = st.hdr[2'(st.cnt + 3'h1)];
					end else if (st.wphase && st.bcnt != LAST_BYTE) begin
						next_st.bcnt = 2'(st.bcnt + 2'h1);
						next_st.shw = {st.shw[23:0], 8'h00};
						next_st.txb = st.shw[23:16];
					end else begin
						next_st.state = (st.words != '0) ? ST_LOAD : ST_RX;
					end
				end
			end
			default: next_st.state = ST_INIT;
		endcase
		// A pulse edge in the same cycle as a new request keeps the request pending
		next_st.snd_pri = next_st.snd_pri | (pps_edge & (st.mask[MASK_PRI] | st.pend_pri)); // R13 R11
		next_st.snd_sup = next_st.snd_sup | (pps_edge & (st.mask[MASK_SUP] | st.pend_sup)); // R15 R14
		next_st.pend_pri = set_pri | (st.pend_pri & ~pps_edge);
		next_st.pend_sup = set_sup | (st.pend_sup & ~pps_edge);
	end

	function automatic logic [31:0] reg_rdata_w(input logic [4:0] a);
		unique case (a)
			A_MASK: reg_rdata_w = {16'h0000, st.mask};
			A_UTC_C: reg_rdata_w = {24'h0, st.utc_c};
			A_A0_HI: reg_rdata_w = st.a0_hi;
			A_A0_LO: reg_rdata_w = st.a0_lo;
			A_A1: reg_rdata_w = st.a1;
			default: reg_rdata_w = '0;
		endcase
	endfunction : reg_rdata_w

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st <= '0;
			st.mask <= MASK_RST;
			st.utc_c <= UTC_C_RST;
		end else begin
			st <= next_st;
		end
	end
endmodule : trcd_cmd_decoder

// ==== test/trcd_checker.sv ====
// Purpose: Port assertions for the command decoder
// Assumes: Bound into every trcd_cmd_decoder
// Notes: Reset disables every check
`timescale 1ns/1ps
module trcd_checker (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic rx_ready,
	input wire logic [7:0] tx_byte,
	input wire logic tx_valid,
	input wire logic tx_last,
	input wire logic tx_ready,
	input wire logic send_primary,
	input wire logic send_supplemental,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
	endsequence
	sequence s_b_late;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	a_tx_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
		else $error("reply byte moved");
	a_rx_blocked: assert property (tx_valid |-> !rx_ready)
		else $error("command taken in reply");
	a_reply_ends: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
		else $error("reply ran on");
	a_pri_pulse: assert property (send_primary |=> !send_primary)
		else $error("primary trigger too long");
	a_sup_pulse: assert property (send_supplemental |=> !send_supplemental)
		else $error("supplemental trigger too long");
	a_wr_answer: assert property (s_wr_taken |=> s_b_late)
		else $error("write answer late");
	a_b_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule : trcd_checker

bind trcd_cmd_decoder trcd_checker chk (.ref_clk(ref_clk), .rst(rst), .rx_ready(rx_ready),
	.tx_byte(tx_byte), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
	.send_primary(send_primary), .send_supplemental(send_supplemental),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// ==== test/trcd_host.sv ====
// Purpose: Host model: sends command bytes, gathers reply bytes
// Assumes: Tasks are entered just after a rising edge
// Notes: A released byte line shows the inverse of its last value
`timescale 1ns/1ps
module trcd_host (
	input wire logic ref_clk,
	input wire logic rx_ready,
	input wire logic [7:0] tx_byte,
	input wire logic tx_valid,
	input wire logic tx_last,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic rx_last,
	output logic tx_ready
);
	logic slow = 1'b0;
	logic [255:0] got = '0;
	int cnt = 0;
	int lastn = 0;
	initial begin
		rx_byte = 8'h00;
		rx_valid = 1'b0;
		rx_last = 1'b0;
		tx_ready = 1'b0;
	end
	// A slow host takes a reply byte only every other cycle
	always @(posedge ref_clk) begin
		if (tx_valid && tx_ready) begin
			got[255 - 8 * cnt -: 8] = tx_byte;
			cnt++;
			if (tx_last) lastn = cnt;
		end
		tx_ready <= slow ? !tx_ready : 1'b1;
	end
	task automatic send(input logic [127:0] pk, input int n, output logic ok);
		int k;
		ok = 1'b1;
		for (int i = 0; i < n; i++) begin
			rx_byte <= pk[127 - 8 * i -: 8];
			rx_valid <= 1'b1;
			rx_last <= (i == n - 1);
			for (k = 0; k < 60; k++) begin
				@(posedge ref_clk);
				if (rx_ready) break;
			end
			if (k == 60) ok = 1'b0;
		end
		rx_valid <= 1'b0;
		rx_last <= 1'b0;
		rx_byte <= ~rx_byte;
	endtask : send
endmodule : trcd_host

// ==== test/testbench.sv ====
// Purpose: Self-checking bench for the command decoder
// Assumes: Host model on the command stream, bench drives AXI and pulse pin
// Notes: Write strobes stay full; per-byte strobes are left unexercised
`timescale 1ns/1ps
module testbench;
	import trcd_pkg::*;
	logic ref_clk = 1'b0, rst = 1'b1, pps_in = 1'b0;
	logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic [4:0] awa = 5'h00, ara = 5'h00;
	logic [31:0] wd = 32'h0, rd, d, seed = 32'h64C4;
	logic [31:0] w [3];
	logic [3:0] ws = 4'hF;
	logic [1:0] br, rr, r;
	logic [7:0] rxb, txb, s;
	logic awr, wr, bv, arr, rv, rxv, rxl, rxr, txv, txl, txr, sp, ss, se, sa, ok;
	logic [255:0] e;
	int n_fail = 0, cmp_count = 0, n;
	trcd_cmd_decoder dut (.ref_clk(ref_clk), .rst(rst), .rx_byte(rxb), .rx_valid(rxv),
		.rx_last(rxl), .rx_ready(rxr), .tx_byte(txb), .tx_valid(txv), .tx_last(txl),
		.tx_ready(txr), .pps_in(pps_in), .send_primary(sp), .send_supplemental(ss),
		.survey_enable(se), .survey_autosave(sa), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre));
	trcd_host host (.ref_clk(ref_clk), .rx_ready(rxr), .tx_byte(txb), .tx_valid(txv),
		.tx_last(txl), .rx_byte(rxb), .rx_valid(rxv), .rx_last(rxl), .tx_ready(txr));
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// Keeps only the first n bytes of a left-aligned reply
	function automatic logic [255:0] trim(input logic [255:0] v, input int n);
		return v & ~({256{1'b1}} >> (8 * n));
	endfunction : trim
	task stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task chk(input string nm, input logic [255:0] x, input logic [255:0] g);
		cmp_count++;
		if (g !== x) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	task tmo(input logic b);
		if (!b) begin
			n_fail++;
			$display("[FAIL] wait expected 1 seen 0");
			stop_test();
		end
	endtask : tmo
	// An edge passes first so a strobe lowered last call is never raised in the same step
	task axw(input logic [4:0] a, input logic [31:0] v, output logic [1:0] rs);
		int k;
		@(posedge ref_clk);
		awa <= a;
		wd <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge ref_clk);
			if (awr) awv <= 1'b0;
			if (wr) wv <= 1'b0;
			if (bv) break;
		end
		rs = br;
		bre <= 1'b0;
		tmo(k < 40);
	endtask : axw
	task axr(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rs);
		int k;
		@(posedge ref_clk);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge ref_clk);
			if (arr) arv <= 1'b0;
			if (rv) break;
		end
		v = rd;
		rs = rr;
		rre <= 1'b0;
		tmo(k < 40);
	endtask : axr
	task xfer(input logic [127:0] pk, input int np, input int nr);
		int k;
		host.slow = 1'(rnd());
		host.cnt = 0;
		host.got = '0;
		host.send(pk, np, ok);
		tmo(ok);
		for (k = 0; k < 90 && host.cnt < nr; k++) @(posedge ref_clk);
		tmo(k < 90);
	endtask : xfer
	task rchk(input string nm, input logic [255:0] x, input int nr);
		chk(nm, trim(x, nr), host.got);
		chk(nm, nr, host.lastn);
	endtask : rchk
	task ppsc(input logic ep, input logic es);
		logic p, q;
		p = 1'b0;
		q = 1'b0;
		pps_in <= 1'b1;
		repeat (8) begin
			@(posedge ref_clk);
			p |= sp;
			q |= ss;
		end
		pps_in <= 1'b0;
		chk("pps triggers", {ep, es}, {p, q});
	endtask : ppsc
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk("survey flags", 0, {se, sa});
		axr(A_MASK, d, r);
		chk("mask reset", MASK_RST, d);
		axr(5'h1C, d, r);
		chk("unmapped read", {RESP_SLVERR, 32'h0}, {r, d});
		axw(A_DROP, 32'h0000_00FF, r);
		chk("ro write", RESP_SLVERR, r);
		axw(A_MASK, 32'h0, r);
		for (int i = 0; i < 5; i++) begin
			s = (i > 2) ? 8'(i - 1) : 8'(i);
			n = (s == 1) ? 3 : (s == 3) ? 1 : 2;
			foreach (w[j]) w[j] = rnd();
			if (i == 2) w[0] = 32'h4120_0000;
			if (i == 3) w[0] = 32'hC000_0000;
			xfer({8'h8E, SUB_DISC, s, w[0], w[1], w[2], 8'h00}, 3 + 4 * n, 3 + 4 * n);
			if (i == 2) w[0] = 32'h0;
			e = {8'h8F, SUB_DISC, s, w[0], w[1], w[2], 136'h0};
			rchk("disc set", e, 3 + 4 * n);
			xfer({8'h8E, SUB_DISC, s, 104'h0}, 3, 3 + 4 * n);
			rchk("disc query", e, 3 + 4 * n);
		end
		xfer({8'h8E, SUB_DISC, 8'h04, 104'h0}, 3, 0);
		repeat (8) @(posedge ref_clk);
		chk("bad selector reply", 0, host.cnt);
		axr(A_DROP, d, r);
		chk("drop count", 1, d);
		xfer({8'h8E, SUB_SURV, 112'h0}, 2, 16);
		rchk("survey default", {8'h8F, SUB_SURV, 16'h0, SLEN_DEF, UNC_MAX, UNC_MAX, 128'h0}, 16);
		d = rnd();
		xfer({8'h8E, SUB_SURV, 16'h0101, d, 32'h0, 32'h4200_0000}, 16, 0);
		repeat (8) @(posedge ref_clk);
		chk("survey flags", 3, {se, sa});
		xfer({8'h8E, SUB_SURV, 112'h0}, 2, 16);
		rchk("survey set", {8'h8F, SUB_SURV, 16'h0101, d, UNC_MAX, 32'h4200_0000, 128'h0}, 16);
		foreach (w[j]) w[j] = rnd();
		axw(A_UTC_C, 32'h3, r);
		axw(A_A0_HI, w[0], r);
		axw(A_A0_LO, w[1], r);
		axw(A_A1, w[2], r);
		xfer({8'h8E, SUB_UTC, 112'h0}, 2, 15);
		rchk("utc", {8'h8F, SUB_UTC, 8'h03, w[0], w[1], w[2], 136'h0}, 15);
		for (int i = 0; i < 6; i++) begin
			xfer({8'h8E, (i < 3) ? SUB_PRI : SUB_SUP, 8'(i % 3), 104'h0}, 3, 0);
			@(posedge ref_clk);
			chk("now", {i == 0, i == 3}, {sp, ss});
			ppsc(i == 1 || i == 2 || i == 5, i == 2 || i == 4 || i == 5);
		end
		axw(A_MASK, 32'h5, r);
		ppsc(1'b1, 1'b1);
		stop_test();
	end
endmodule : testbench
